// ---- logic/hbs_status_irq.sv ----
// HDLC/BOC event status register, interrupt mask register and interrupt pin.
// Assumes host strobes are one-cycle, synchronous to clk, and FIFO levels
// arrive as occupancy counts from the FIFOs themselves.
//
// How it works
// RULE1: a change of the code-detected level, either way, sets the code change flag.
// RULE2: a valid message, CRC error, overrun or abort sets the packet end flag.
// RULE3: the opening byte of a new packet sets the packet start flag.
// RULE4: the receive half-full flag is high while the receive FIFO holds more than half its depth.
// RULE5: the receive not-empty flag is high while the receive FIFO holds at least one byte.
// RULE6: the transmit half-empty flag is high while the transmit FIFO holds less than half its depth.
// RULE7: the transmit not-full flag is high while the transmit FIFO has room for one more byte.
// RULE8: the end of a transmitted message sets the message done flag.
// RULE9: the four event flags are latched and cleared by a host read of the status register.
// RULE10: each mask bit gates the flag at its position, 0 blocking and 1 passing it.
// RULE11: the active-low interrupt is asserted while any unmasked flag is set and released once cleared.
// RULE12: the four FIFO level flags are live and unaffected by status reads.
// RULE13: the interrupt request is the OR over all positions of flag AND mask.
`timescale 1ns/10ps
`default_nettype none

module hbs_status_irq
    import hbs_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = HBS_FIFO_DEPTH,
    parameter int unsigned CNT_W      = $clog2(FIFO_DEPTH + 1)
) (
    input  wire logic                   clk,        // 100 MHz clock
    input  wire logic                   rst_n,      // synchronous reset, active low
    input  wire hbs_pkg::hbs_host_req_t host_req,   // control port request
    input  wire hbs_pkg::hbs_events_t   events,     // event pulses and levels
    input  wire logic [CNT_W-1:0]       rx_count,   // receive FIFO occupancy
    input  wire logic [CNT_W-1:0]       tx_count,   // transmit FIFO occupancy
    output logic [HBS_DATA_W-1:0]       rd_data,    // read data, registered
    output logic                        int_n       // interrupt, active low
);
    import hbs_pkg::*;

    localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(FIFO_DEPTH / 2);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);

    hbs_state_t st_r;
    hbs_state_t st_nxt;

    logic [7:0] live;
    logic [7:0] set_ev;
    logic [7:0] status_view;
    logic       status_rd;
    logic       mask_wr;
    logic       irq_nxt;

    always_comb begin
        // RULE12: live level flags
        live = 8'h00;
        // RULE4: receive above half
        live[HBS_BIT_RX_FIFO_HALF_FULL]  = rx_count > HALF_CNT;
        // RULE5: receive has data
        live[HBS_BIT_RX_FIFO_NOT_EMPTY]  = rx_count != '0;
        // RULE6: transmit below half
        live[HBS_BIT_TX_FIFO_HALF_EMPTY] = tx_count < HALF_CNT;
        // RULE7: transmit has room
        live[HBS_BIT_TX_FIFO_NOT_FULL]   = tx_count < FULL_CNT;

        set_ev = 8'h00;
        // RULE1: detector state change
        set_ev[HBS_BIT_RX_CODE_CHANGE]  = events.boc_detected ^ st_r.bd_prev;
        // RULE2: packet end causes
        set_ev[HBS_BIT_RX_PACKET_END]   = events.rx_valid_msg | events.rx_crc_err
                                        | events.rx_overrun | events.rx_abort;
        // RULE3: opening byte seen
        set_ev[HBS_BIT_RX_PACKET_START] = events.rx_open_byte;
        // RULE8: message sent
        set_ev[HBS_BIT_TX_MESSAGE_DONE] = events.tx_msg_done;

        status_view = (st_r.latched & HBS_LATCHED_MASK) | live;
        status_rd   = host_req.rd && (host_req.addr == HBS_OFF_EVENT_STATUS);
        mask_wr     = host_req.wr && (host_req.addr == HBS_OFF_EVENT_MASK);

        st_nxt         = st_r;
        st_nxt.bd_prev = events.boc_detected;

        // RULE9: clear on read, set wins
        st_nxt.latched = ((status_rd ? 8'h00 : st_r.latched) | set_ev) & HBS_LATCHED_MASK;

        // RULE10: mask register write
        if (mask_wr) begin
            st_nxt.mask = host_req.wdata;
        end

        if (host_req.rd) begin
            case (host_req.addr)
                HBS_OFF_EVENT_STATUS: st_nxt.rdata = status_view;
                HBS_OFF_EVENT_MASK:   st_nxt.rdata = st_r.mask;
                default:              st_nxt.rdata = HBS_UNMAPPED_RD;
            endcase
        end

        // next-state flags and mask, so a mask write acts at once
        // RULE13: OR of flag AND mask
        irq_nxt = |((st_nxt.latched | live) & st_nxt.mask);
        // RULE11: pin low while pending
        st_nxt.int_n = ~irq_nxt;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // detector high at release reads as a change
            st_r.bd_prev <= 1'b0;
            st_r.latched <= HBS_RST_LATCHED;
            st_r.mask    <= HBS_RST_MASK;
            st_r.rdata   <= HBS_RST_RDATA;
            st_r.int_n   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data = st_r.rdata;
    assign int_n   = st_r.int_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CODE_CHANGE_SETS: assert property ( // RULE1
        (events.boc_detected != st_r.bd_prev) |=> st_r.latched[HBS_BIT_RX_CODE_CHANGE])
        else $error("code change flag not set after detector change");

    AST_PACKET_END_SETS: assert property ( // RULE2
        (events.rx_valid_msg || events.rx_crc_err || events.rx_overrun || events.rx_abort)
        |=> st_r.latched[HBS_BIT_RX_PACKET_END])
        else $error("packet end flag not set");

    AST_PACKET_START_SETS: assert property ( // RULE3
        events.rx_open_byte |=> st_r.latched[HBS_BIT_RX_PACKET_START])
        else $error("packet start flag not set");

    AST_RX_HALF_LIVE: assert property ( // RULE4
        status_view[HBS_BIT_RX_FIFO_HALF_FULL] == (rx_count > HALF_CNT))
        else $error("receive half-full flag wrong");

    AST_RX_NOT_EMPTY_LIVE: assert property ( // RULE5
        (rx_count == '0) |-> !status_view[HBS_BIT_RX_FIFO_NOT_EMPTY])
        else $error("receive not-empty flag set while empty");

    AST_TX_HALF_LIVE: assert property ( // RULE6
        status_view[HBS_BIT_TX_FIFO_HALF_EMPTY] == (tx_count < HALF_CNT))
        else $error("transmit half-empty flag wrong");

    AST_TX_NOT_FULL_LIVE: assert property ( // RULE7
        (tx_count == FULL_CNT) |-> !status_view[HBS_BIT_TX_FIFO_NOT_FULL])
        else $error("transmit not-full flag set while full");

    AST_MSG_DONE_SETS: assert property ( // RULE8
        events.tx_msg_done |=> st_r.latched[HBS_BIT_TX_MESSAGE_DONE])
        else $error("message done flag not set");

    AST_READ_CLEARS: assert property ( // RULE9
        (status_rd && set_ev == 8'h00) |=> (st_r.latched == 8'h00)
        && (rd_data == $past(status_view)))
        else $error("status read did not return and clear latched flags");

    AST_MASK_WRITE: assert property ( // RULE10
        mask_wr |=> st_r.mask == $past(host_req.wdata))
        else $error("mask register did not take written value");

    // a mask write in the same cycle may legally drop the request
    AST_IRQ_PENDING: assert property ( // RULE11
        (|(st_r.latched & st_r.mask) && !status_rd && !mask_wr)
        |=> !int_n)
        else $error("interrupt not asserted for pending unmasked flag");

    AST_IRQ_RELEASE: assert property ( // RULE13
        (st_r.mask == 8'h00 && !mask_wr)
        |=> int_n)
        else $error("interrupt asserted with all flags masked");

    // level flags must survive the read edge unchanged
    AST_LIVE_UNTOUCHED: assert property ( // RULE12
        status_rd ##1 ($stable(rx_count) && $stable(tx_count))
        |-> status_view[4:1] == $past(status_view[4:1]))
        else $error("status read changed a level flag");

    AST_RESET_VALUES: assert property ( // RULE11
        $rose(rst_n)
        |-> int_n && (rd_data == HBS_RST_RDATA) && (st_r.mask == HBS_RST_MASK)
            && (st_r.latched == HBS_RST_LATCHED))
        else $error("state after reset differs from reset values");

    AST_BD_TRACKS: assert property ( // RULE1
        1'b1
        |=> st_r.bd_prev == $past(events.boc_detected))
        else $error("previous code level not tracked");

    // event flags: no set without a cause
    AST_CODE_QUIET: assert property ( // RULE1
        (events.boc_detected == st_r.bd_prev) && !st_r.latched[HBS_BIT_RX_CODE_CHANGE]
        |=> !st_r.latched[HBS_BIT_RX_CODE_CHANGE])
        else $error("code change flag set without a change");

    AST_END_QUIET: assert property ( // RULE2
        !(events.rx_valid_msg || events.rx_crc_err || events.rx_overrun || events.rx_abort)
            && !st_r.latched[HBS_BIT_RX_PACKET_END]
        |=> !st_r.latched[HBS_BIT_RX_PACKET_END])
        else $error("packet end flag set without a cause");

    AST_START_QUIET: assert property ( // RULE3
        !events.rx_open_byte && !st_r.latched[HBS_BIT_RX_PACKET_START]
        |=> !st_r.latched[HBS_BIT_RX_PACKET_START])
        else $error("packet start flag set without an opening byte");

    AST_DONE_QUIET: assert property ( // RULE8
        !events.tx_msg_done && !st_r.latched[HBS_BIT_TX_MESSAGE_DONE]
        |=> !st_r.latched[HBS_BIT_TX_MESSAGE_DONE])
        else $error("message done flag set without a finished message");

    AST_RX_NOT_EMPTY_SET: assert property ( // RULE5
        (rx_count != '0)
        |-> status_view[HBS_BIT_RX_FIFO_NOT_EMPTY])
        else $error("receive not-empty flag clear while data held");

    AST_TX_NOT_FULL_SET: assert property ( // RULE7
        (tx_count < FULL_CNT)
        |-> status_view[HBS_BIT_TX_FIFO_NOT_FULL])
        else $error("transmit not-full flag clear while room left");

    // latched flags: held until read, set wins over the clear
    AST_LATCH_HOLDS: assert property ( // RULE9
        !status_rd
        |=> (st_r.latched & $past(st_r.latched)) == $past(st_r.latched))
        else $error("latched flag lost without a status read");

    AST_SET_WINS: assert property ( // RULE9
        status_rd && (set_ev != 8'h00)
        |=> (st_r.latched & $past(set_ev)) == $past(set_ev))
        else $error("event in the read cycle was lost");

    AST_STATUS_WRITE_IGNORED: assert property ( // RULE9
        host_req.wr && !host_req.rd && (host_req.addr == HBS_OFF_EVENT_STATUS) && (set_ev == 8'h00)
        |=> st_r.latched == $past(st_r.latched))
        else $error("write to the status register changed a flag");

    // read port: data stands until the next read
    AST_RDATA_HOLDS: assert property ( // RULE9
        !host_req.rd
        |=> $stable(rd_data))
        else $error("read data changed without a read");

    AST_STATUS_READ_DATA: assert property ( // RULE12
        status_rd
        |=> rd_data[4:1] == $past(live[4:1]))
        else $error("status read did not return the live levels");

    AST_MASK_READBACK: assert property ( // RULE10
        host_req.rd && (host_req.addr == HBS_OFF_EVENT_MASK)
        |=> rd_data == $past(st_r.mask))
        else $error("mask read did not return the mask");

    AST_MASK_HOLDS: assert property ( // RULE10
        !mask_wr
        |=> $stable(st_r.mask))
        else $error("mask changed without a mask write");

    AST_UNMAPPED_READ: assert property ( // RULE10
        host_req.rd && (host_req.addr != HBS_OFF_EVENT_STATUS) && (host_req.addr != HBS_OFF_EVENT_MASK)
        |=> rd_data == HBS_UNMAPPED_RD)
        else $error("unmapped read returned nonzero data");

    // interrupt pin against the masked flags
    AST_IRQ_PENDING_LIVE: assert property ( // RULE11
        (|(live & st_r.mask)) && !mask_wr
        |=> !int_n)
        else $error("interrupt not asserted for an unmasked level flag");

    AST_IRQ_QUIET: assert property ( // RULE11
        (((st_r.latched | live) & st_r.mask) == 8'h00) && (set_ev == 8'h00) && !mask_wr
        |=> int_n)
        else $error("interrupt asserted with nothing pending");

    // level flags reach the pin one register stage late
    AST_IRQ_IS_OR: assert property ( // RULE13
        1'b1
        |=> int_n == !(|((st_r.latched | $past(live)) & st_r.mask)))
        else $error("interrupt differs from the OR of masked flags");

    // RULE10 per position gate
    for (genvar gi = 0; gi < 8; gi++) begin : g_pos
        AST_POS_PASSES: assert property ( // RULE10
            (live[gi] || (st_r.latched[gi] && !status_rd)) && st_r.mask[gi] && !mask_wr
            |=> !int_n)
            else $error("unmasked flag did not drive the interrupt");
    end

    COV_READ_WITH_IRQ: cover property (!int_n ##1 status_rd ##1 int_n);
    COV_SET_DURING_READ: cover property (status_rd && set_ev != 8'h00);
    COV_MASK_THEN_EVENT: cover property (mask_wr ##[1:5] events.rx_open_byte ##1 !int_n);
    COV_LEVEL_IRQ_DROPS: cover property (mask_wr ##1 !int_n ##[1:5] int_n);
    COV_UNMAPPED_READ: cover property (host_req.rd && !status_rd && host_req.addr != HBS_OFF_EVENT_MASK);

endmodule // hbs_status_irq

`default_nettype wire

// ---- pkg/hbs_pkg.sv ----
// Package for the HDLC/BOC status flag and interrupt mask block.
// Assumes a byte-wide host control port with separate read and write strobes.
package hbs_pkg;

    localparam int unsigned HBS_ADDR_W = 8;
    localparam int unsigned HBS_DATA_W = 8;

    // register offsets on the control port
    localparam logic [7:0] HBS_OFF_EVENT_STATUS = 8'h01;
    localparam logic [7:0] HBS_OFF_EVENT_MASK   = 8'h02;

    // bit positions shared by status and mask
    localparam int unsigned HBS_BIT_RX_CODE_CHANGE    = 7;
    localparam int unsigned HBS_BIT_RX_PACKET_END     = 6;
    localparam int unsigned HBS_BIT_RX_PACKET_START   = 5;
    localparam int unsigned HBS_BIT_RX_FIFO_HALF_FULL = 4;
    localparam int unsigned HBS_BIT_RX_FIFO_NOT_EMPTY = 3;
    localparam int unsigned HBS_BIT_TX_FIFO_HALF_EMPTY = 2;
    localparam int unsigned HBS_BIT_TX_FIFO_NOT_FULL  = 1;
    localparam int unsigned HBS_BIT_TX_MESSAGE_DONE   = 0;

    // latched (clear-on-read) positions
    localparam logic [7:0] HBS_LATCHED_MASK = 8'hE1;

    // values after reset
    localparam logic [7:0] HBS_RST_LATCHED = 8'h00;
    localparam logic [7:0] HBS_RST_MASK    = 8'h00;
    localparam logic [7:0] HBS_RST_RDATA   = 8'h00;
    localparam logic [7:0] HBS_UNMAPPED_RD = 8'h00;

    // default FIFO depth in bytes
    localparam int unsigned HBS_FIFO_DEPTH = 64;

    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic [HBS_ADDR_W-1:0] addr;
        logic [HBS_DATA_W-1:0] wdata;
    } hbs_host_req_t;

    typedef struct packed {
        logic boc_detected;   // real-time code detector level
        logic rx_valid_msg;   // pulse: message passed CRC check
        logic rx_crc_err;     // pulse
        logic rx_overrun;     // pulse
        logic rx_abort;       // pulse
        logic rx_open_byte;   // pulse: opening byte of packet seen
        logic tx_msg_done;    // pulse: last byte of message sent
    } hbs_events_t;

    typedef struct packed {
        logic                  bd_prev;
        logic [7:0]            latched;
        logic [7:0]            mask;
        logic [HBS_DATA_W-1:0] rdata;
        logic                  int_n;
    } hbs_state_t;

endpackage

// ---- tb/hbs_host_model.sv ----
// Host processor model for the control port of the status block.
// Assumes the bench calls access() and that strobes are one cycle long.
`timescale 1ns/10ps
`default_nettype none

module hbs_host_model
    import hbs_pkg::*;
(
    input  wire logic               clk,  // bench clock
    output var hbs_pkg::hbs_host_req_t req   // control port request
);
    import hbs_pkg::*;

    initial req = '0;

    // strobe for one cycle, then park address and data inverted
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // hbs_host_model

`default_nettype wire

// ---- tb/hbs_status_irq_tb_top.sv ----
// Self-checking bench for the status and mask block.
// Assumes the default FIFO depth of 64 and registered read data.
`timescale 1ns/10ps
`default_nettype none

module hbs_status_irq_tb_top;
    import hbs_pkg::*;
    logic          clk = 0;
    logic          rst_n = 0;
    logic          boc = 0;
    logic [5:0]    pls = '0;
    logic [6:0]    rx = '0;
    logic [6:0]    tx = '0;
    logic [7:0]    rd_data, e;
    logic          int_n, seen = 0;
    hbs_events_t   ev;
    hbs_host_req_t host_req;
    logic [7:0]    exp_q[$];
    int            fails = 0, n_tests = 0;
    int            b[6] = '{0, 1, 32, 33, 63, 64};
    assign ev = {boc, pls};

    hbs_host_model host (.clk(clk), .req(host_req));
    hbs_status_irq dut (.clk(clk), .rst_n(rst_n), .host_req(host_req), .events(ev),
        .rx_count(rx), .tx_count(tx), .rd_data(rd_data), .int_n(int_n));

    initial forever #5 clk = ~clk;

    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        n_tests++;
        if (s !== x) begin
            fails++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, s, x);
        end
    endtask

    function automatic logic [7:0] lvl();
        return {3'h0, rx > 32, rx != 0, tx < 32, tx < 64, 1'b0};
    endfunction

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        host.access(1'b0, a, 8'h00);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // read data lands one cycle after the read edge
    always @(posedge clk) seen <= host_req.rd;
    always @(negedge clk) if (seen) chk(rd_data, exp_q.pop_front());

    initial begin
        #50000;
        fails++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(31));
        repeat (3) @(negedge clk);
        rst_n <= 1;
        chk({7'h0, int_n}, 8'h01);
        rd(HBS_OFF_EVENT_MASK, HBS_RST_MASK);
        rd(HBS_OFF_EVENT_STATUS, lvl());
        $display("test reset done");
        for (int k = 0; k < 7; k++) begin
            e = (k < 4) ? 8'h40 : (k == 4) ? 8'h20 : (k == 5) ? 8'h01 : 8'h80;
            host.access(1'b1, HBS_OFF_EVENT_MASK, e);
            @(negedge clk);
            if (k == 6) boc <= ~boc;
            else pls <= 6'h20 >> k;
            @(negedge clk);
            pls <= '0;
            chk({7'h0, int_n}, 8'h00);
            rd(HBS_OFF_EVENT_STATUS, e | lvl());
            chk({7'h0, int_n}, 8'h01);
            rd(HBS_OFF_EVENT_STATUS, lvl());
        end
        $display("test events done");
        host.access(1'b1, HBS_OFF_EVENT_MASK, 8'h00);
        for (int i = 0; i < 12; i++) begin
            rx = (i < 6) ? 7'(b[i]) : 7'($urandom_range(64));
            tx = (i < 6) ? 7'(b[5 - i]) : 7'($urandom_range(64));
            rd(HBS_OFF_EVENT_STATUS, lvl());
            rd(HBS_OFF_EVENT_STATUS, lvl());
        end
        $display("test levels done");
        rx = 7'd40;
        host.access(1'b1, HBS_OFF_EVENT_MASK, 8'h10);
        repeat (2) @(negedge clk);
        chk({7'h0, int_n}, 8'h00);
        rx = 7'd10;
        repeat (2) @(negedge clk);
        chk({7'h0, int_n}, 8'h01);
        e = 8'($urandom);
        host.access(1'b1, HBS_OFF_EVENT_MASK, e);
        host.access(1'b1, HBS_OFF_EVENT_STATUS, ~e);
        rd(HBS_OFF_EVENT_STATUS, lvl());
        rd(HBS_OFF_EVENT_MASK, e);
        rd(8'h03, HBS_UNMAPPED_RD);
        // event in the read cycle: read misses it, flag still set after
        exp_q.push_back(lvl());
        fork
            host.access(1'b0, HBS_OFF_EVENT_STATUS, 8'h00);
            begin
                @(negedge clk);
                pls <= 6'h01;
                @(negedge clk);
                pls <= '0;
            end
        join
        rd(HBS_OFF_EVENT_STATUS, 8'h01 | lvl());
        @(negedge clk);
        $display("test mask done");
        tally_and_finish();
    end
endmodule // hbs_status_irq_tb_top

`default_nettype wire
